/* verilog/crs_strap_decoder.sv */
// Purpose: Capture clock ratio straps after power-on reset and steer clock enables
// Assumes: Strap pins and PLL tick pulses are synchronous to sys_clk
// Notes: PLL analog behaviour lives outside; this block selects and gates
//
// Local design decisions: the placing of the registers and the plain strobed port.

`timescale 1ns/1ns

module crs_strap_decoder #(
    parameter int DATA_W = 32,
    parameter int MEMCK_PINS = 6
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [2:0] platform_ratio_straps,
    input wire logic core0_ratio_strap_hi,
    input wire logic core0_ratio_strap_mid,
    input wire logic core0_ratio_strap_lo,
    input wire logic core1_ratio_strap_hi,
    input wire logic core1_ratio_strap_mid,
    input wire logic core1_ratio_strap_lo,
    input wire logic mem_ratio_strap_hi,
    input wire logic mem_ratio_strap_mid,
    input wire logic mem_ratio_strap_lo,
    input wire logic platform_tick,
    input wire logic mem_pll_tick,
    input wire logic [crs_pkg::CRS_ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    output crs_pkg::crs_cfg_t clk_cfg,
    output logic cfg_valid,
    output logic platform_run,
    output logic bus_tick,
    output logic core0_clk_en,
    output logic core1_clk_en,
    output logic mem_pll_enable,
    output logic mem_data_tick,
    output logic [MEMCK_PINS-1:0] memory_clock_outputs_ctl0,
    output logic [MEMCK_PINS-1:0] memory_clock_outputs_ctl0_inv,
    output logic [MEMCK_PINS-1:0] memory_clock_outputs_ctl1,
    output logic [MEMCK_PINS-1:0] memory_clock_outputs_ctl1_inv
);

    // ************************************************************
    // Declarations
    // ************************************************************
    crs_pkg::crs_straps_t straps_in;
    crs_pkg::crs_straps_t straps_r;
    crs_pkg::crs_straps_t straps_nxt;
    crs_pkg::crs_cfg_t cfg_r;
    crs_pkg::crs_cfg_t cfg_nxt;
    logic captured_r;
    logic captured_nxt;
    logic memck_r;
    logic memck_nxt;
    logic memck_en_r;
    logic memck_en_nxt;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;
    logic mem_run;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    assign straps_in = '{
        plat: platform_ratio_straps,
        core0: {core0_ratio_strap_hi, core0_ratio_strap_mid, core0_ratio_strap_lo},
        core1: {core1_ratio_strap_hi, core1_ratio_strap_mid, core1_ratio_strap_lo},
        mem: {mem_ratio_strap_hi, mem_ratio_strap_mid, mem_ratio_strap_lo}
    };

    // ************************************************************
    // Strap capture and decode
    // ************************************************************
    always_comb
    begin
        straps_nxt = straps_r;
        captured_nxt = captured_r;
        cfg_nxt = cfg_r;
        if (!captured_r)
        begin
            straps_nxt = straps_in;
            captured_nxt = 1'b1;
            cfg_nxt.plat_err = straps_in.plat > crs_pkg::CRS_PLAT_LAST_CODE;
            cfg_nxt.plat_mult = cfg_nxt.plat_err ? 4'h0 :
                crs_pkg::CRS_PLAT_MULT[straps_in.plat];
            cfg_nxt.core0_err = straps_in.core0 < crs_pkg::CRS_CORE_FIRST_CODE;
            cfg_nxt.core0_halves = cfg_nxt.core0_err ? 4'h0 :
                crs_pkg::CRS_CORE_HALVES[straps_in.core0 - crs_pkg::CRS_CORE_FIRST_CODE];
            cfg_nxt.core1_err = straps_in.core1 < crs_pkg::CRS_CORE_FIRST_CODE;
            cfg_nxt.core1_halves = cfg_nxt.core1_err ? 4'h0 :
                crs_pkg::CRS_CORE_HALVES[straps_in.core1 - crs_pkg::CRS_CORE_FIRST_CODE];
            cfg_nxt.mem_async = straps_in.mem != crs_pkg::CRS_MEM_SYNC_CODE;
            cfg_nxt.mem_mult = cfg_nxt.mem_async ?
                crs_pkg::CRS_MEM_MULT[straps_in.mem] : 4'h0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            straps_r <= '0;
            captured_r <= 1'b0;
            cfg_r <= '0;
        end
        else
        begin
            straps_r <= straps_nxt;
            captured_r <= captured_nxt;
            cfg_r <= cfg_nxt;
        end
    end

    assign clk_cfg = cfg_r;
    assign cfg_valid = captured_r;

    // ************************************************************
    // Clock gating and source selection
    // ************************************************************
    // errors keep the affected clocks stopped
    assign platform_run = captured_r & ~cfg_r.plat_err;
    assign core0_clk_en = platform_run & ~cfg_r.core0_err;
    assign core1_clk_en = platform_run & ~cfg_r.core1_err;
    // bus tick is the platform tick itself while platform_run is high
    assign bus_tick = platform_tick & platform_run;
    assign mem_run = platform_run & memck_en_r;
    // PLL on the memory reference clock, async only
    assign mem_pll_enable = platform_run & cfg_r.mem_async;
    // sync data rate equals platform rate
    assign mem_data_tick = mem_run & (cfg_r.mem_async ? mem_pll_tick : platform_tick);

    // ************************************************************
    // Memory clock outputs
    // ************************************************************
    always_comb
    begin
        memck_nxt = memck_r;
        // toggle per data tick gives half rate
        if (mem_data_tick)
        begin
            memck_nxt = ~memck_r;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            memck_r <= 1'b0;
        end
        else
        begin
            memck_r <= memck_nxt;
        end
    end

    // one divider feeds both controllers, so modes cannot differ
    assign memory_clock_outputs_ctl0 = {MEMCK_PINS{memck_r}};
    assign memory_clock_outputs_ctl0_inv = {MEMCK_PINS{~memck_r}};
    assign memory_clock_outputs_ctl1 = {MEMCK_PINS{memck_r}};
    assign memory_clock_outputs_ctl1_inv = {MEMCK_PINS{~memck_r}};

    // ************************************************************
    // Register port
    // ************************************************************
    always_comb
    begin
        memck_en_nxt = memck_en_r;
        rdata_nxt = '0;
        if (reg_wr && reg_addr == crs_pkg::CRS_ADDR_CTRL)
        begin
            memck_en_nxt = reg_wdata[crs_pkg::CRS_CT_MEMCK_EN];
        end
        if (reg_rd)
        begin
            case (reg_addr)
                crs_pkg::CRS_ADDR_STATUS:
                begin
                    rdata_nxt[crs_pkg::CRS_ST_CAPTURED] = captured_r;
                    rdata_nxt[crs_pkg::CRS_ST_PLAT_ERR] = cfg_r.plat_err;
                    rdata_nxt[crs_pkg::CRS_ST_CORE0_ERR] = cfg_r.core0_err;
                    rdata_nxt[crs_pkg::CRS_ST_CORE1_ERR] = cfg_r.core1_err;
                    rdata_nxt[crs_pkg::CRS_ST_MEM_ASYNC] = cfg_r.mem_async;
                    rdata_nxt[crs_pkg::CRS_ST_PLAT_RUN] = platform_run;
                end
                crs_pkg::CRS_ADDR_RATIO:
                begin
                    rdata_nxt[crs_pkg::CRS_RT_PLAT +: 4] = cfg_r.plat_mult;
                    rdata_nxt[crs_pkg::CRS_RT_CORE0 +: 4] = cfg_r.core0_halves;
                    rdata_nxt[crs_pkg::CRS_RT_CORE1 +: 4] = cfg_r.core1_halves;
                    rdata_nxt[crs_pkg::CRS_RT_MEM +: 4] = cfg_r.mem_mult;
                    rdata_nxt[crs_pkg::CRS_RT_RAW +: 12] = straps_r;
                end
                crs_pkg::CRS_ADDR_CTRL:
                begin
                    rdata_nxt[crs_pkg::CRS_CT_MEMCK_EN] = memck_en_r;
                end
                default:
                begin
                    rdata_nxt = '0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            memck_en_r <= crs_pkg::CRS_CTRL_MEMCK_EN_RST;
            rdata_r <= '0;
        end
        else
        begin
            memck_en_r <= memck_en_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence s_first_capture;
        !captured_r ##1 captured_r;
    endsequence

    sequence s_data_tick;
        mem_data_tick;
    endsequence

    a_capture_hold: assert property (captured_r |=> captured_r && $stable(cfg_r)
        && $stable(straps_r)) else $error("strap capture changed after reset");

    a_plat_decode: assert property (s_first_capture |-> (straps_r.plat == 3'h0
        ? cfg_r.plat_mult == 4'h4 : 1'b1) && (straps_r.plat == 3'h5
        ? cfg_r.plat_mult == 4'hC : 1'b1)) else $error("platform multiplier wrong");

    a_plat_reserved: assert property (captured_r && straps_r.plat[2:1] == 2'h3
        |-> cfg_r.plat_err && !platform_run && !core0_clk_en && !core1_clk_en
        && !bus_tick) else $error("reserved platform code not trapped");

    a_core0_decode: assert property (captured_r && straps_r.core0 >= 3'h3
        |-> cfg_r.core0_halves == {1'b0, straps_r.core0} && !cfg_r.core0_err)
        else $error("core0 ratio wrong");

    a_core1_reserved: assert property (captured_r && straps_r.core1 < 3'h3
        |-> cfg_r.core1_err && !core1_clk_en) else $error("core1 reserved missed");

    a_core_indep: assert property (captured_r && platform_run |->
        core0_clk_en == (straps_r.core0 >= 3'h3)
        && core1_clk_en == (straps_r.core1 >= 3'h3)) else $error("core enables coupled");

    a_mem_decode: assert property (captured_r && straps_r.mem == 3'h6
        |-> cfg_r.mem_mult == 4'hE && cfg_r.mem_async) else $error("memory ratio wrong");

    a_mem_sync: assert property (captured_r && straps_r.mem == 3'h7
        |-> !cfg_r.mem_async && !mem_pll_enable) else $error("sync code not honoured");

    // sync source is the platform tick
    a_sync_source: assert property (mem_run && !cfg_r.mem_async
        |-> mem_data_tick == platform_tick) else $error("sync memory source wrong");

    // async source is the memory PLL
    a_async_source: assert property (mem_run && cfg_r.mem_async
        |-> mem_data_tick == mem_pll_tick && mem_pll_enable)
        else $error("async memory source wrong");

    // each data tick flips the memory clock once
    a_half_rate: assert property (s_data_tick |=> memory_clock_outputs_ctl0[0]
        != $past(memory_clock_outputs_ctl0[0])) else $error("memory clock not halved");

    a_both_ctrl: assert property (memory_clock_outputs_ctl0 == memory_clock_outputs_ctl1)
        else $error("controllers differ");

    a_bus_same: assert property (platform_run |-> bus_tick == platform_tick)
        else $error("bus tick differs from platform");

endmodule

/* verilog/crs_pkg.sv */
// Purpose: Shared constants and carriers for the clock ratio strap decoder
// Assumes: Three-bit strap groups, 32-bit register port with byte addresses
// Notes: Multipliers are whole numbers; core ratios are counted in halves

package crs_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int CRS_ADDR_W = 4;
    localparam logic [3:0] CRS_ADDR_STATUS = 4'h0;
    localparam logic [3:0] CRS_ADDR_RATIO = 4'h4;
    localparam logic [3:0] CRS_ADDR_CTRL = 4'h8;

    // Status field positions
    localparam int CRS_ST_CAPTURED = 0;
    localparam int CRS_ST_PLAT_ERR = 1;
    localparam int CRS_ST_CORE0_ERR = 2;
    localparam int CRS_ST_CORE1_ERR = 3;
    localparam int CRS_ST_MEM_ASYNC = 4;
    localparam int CRS_ST_PLAT_RUN = 5;

    // Ratio field positions
    localparam int CRS_RT_PLAT = 0;
    localparam int CRS_RT_CORE0 = 4;
    localparam int CRS_RT_CORE1 = 8;
    localparam int CRS_RT_MEM = 12;
    localparam int CRS_RT_RAW = 16;

    // Control field position and reset value
    localparam int CRS_CT_MEMCK_EN = 0;
    localparam logic CRS_CTRL_MEMCK_EN_RST = 1'h1;

    // ************************************************************
    // Strap codes and decode tables
    // ************************************************************
    localparam logic [2:0] CRS_PLAT_LAST_CODE = 3'h5;
    localparam logic [2:0] CRS_CORE_FIRST_CODE = 3'h3;
    localparam logic [2:0] CRS_MEM_SYNC_CODE = 3'h7;
    localparam logic [3:0] CRS_PLAT_MULT [0:5] = '{4'h4, 4'h5, 4'h6, 4'h8, 4'hA, 4'hC};
    localparam logic [3:0] CRS_CORE_HALVES [0:4] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
    localparam logic [3:0] CRS_MEM_MULT [0:6] = '{4'h3, 4'h4, 4'h6, 4'h8, 4'hA, 4'hC, 4'hE};

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic [2:0] plat;
        logic [2:0] core0;
        logic [2:0] core1;
        logic [2:0] mem;
    } crs_straps_t;

    typedef struct packed {
        logic [3:0] plat_mult;
        logic [3:0] core0_halves;
        logic [3:0] core1_halves;
        logic [3:0] mem_mult;
        logic mem_async;
        logic plat_err;
        logic core0_err;
        logic core1_err;
    } crs_cfg_t;

endpackage

/* test/crs_board_model.sv */
// Purpose: Board side of the strap decoder: strap resistors and PLL tick sources
// Assumes: Straps come from the bench; ticks are abstract clock periods
// Notes: Shared pins wander after capture so a late resample would show

`timescale 1ns/1ns

module crs_board_model #(
    parameter int PLAT_DIV = 3,
    parameter int MEM_DIV = 2
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire crs_pkg::crs_straps_t straps,
    output logic [11:0] pins,
    output logic platform_tick,
    output logic mem_pll_tick
);
    // ************************************************************
    // Strap resistors
    // ************************************************************
    logic captured_r = 1'b0;
    int plat_cnt = 0;
    int mem_cnt = 0;

    initial pins = 12'h000;
    initial platform_tick = 1'b0;
    initial mem_pll_tick = 1'b0;

    always @(posedge sys_clk)
    begin
        captured_r <= reset_n;
        if (!reset_n || !captured_r)
            pins <= straps;
        else
            pins <= ~pins;
    end

    // ************************************************************
    // Tick sources
    // ************************************************************
    // memory rate above platform rate
    always @(posedge sys_clk)
    begin
        plat_cnt <= (plat_cnt == PLAT_DIV - 1) ? 0 : plat_cnt + 1;
        mem_cnt <= (mem_cnt == MEM_DIV - 1) ? 0 : mem_cnt + 1;
        platform_tick <= (plat_cnt == 0);
        // reference unused in sync; line wanders
        if (straps.mem == 3'h7)
            mem_pll_tick <= ~mem_pll_tick;
        else
            mem_pll_tick <= (mem_cnt == 0);
    end
endmodule

/* test/tb.sv */
// Purpose: Self-checking bench for the clock ratio strap decoder
// Assumes: Register port answers one cycle after a read strobe
// Notes: Each strap set is applied across a fresh reset, then watched

`timescale 1ns/1ns

module tb;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    crs_pkg::crs_straps_t straps = 12'h000;
    logic [11:0] pins;
    logic platform_tick;
    logic mem_pll_tick;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    crs_pkg::crs_cfg_t clk_cfg;
    logic cfg_valid, platform_run, bus_tick, core0_clk_en, core1_clk_en;
    logic mem_pll_enable, mem_data_tick;
    logic [5:0] mck0, mck0_n, mck1, mck1_n;
    int error_cnt = 0;
    int n_compared = 0;
    logic mon_on = 1'b0;
    logic mon_prev = 1'b0;
    logic exp_en = 1'b1;
    logic exp_run = 1'b0;
    logic exp_async = 1'b0;
    logic prev_tick = 1'b0;
    logic [5:0] prev_mck = 6'h00;
    localparam logic [3:0] PM [0:7] = '{4'h4, 4'h5, 4'h6, 4'h8, 4'hA, 4'hC, 4'h0, 4'h0};
    localparam logic [3:0] MM [0:7] = '{4'h3, 4'h4, 4'h6, 4'h8, 4'hA, 4'hC, 4'hE, 4'h0};

    always #50 sys_clk = ~sys_clk;

    crs_board_model u_crs_board_model (.sys_clk(sys_clk), .reset_n(reset_n), .straps(straps),
        .pins(pins), .platform_tick(platform_tick), .mem_pll_tick(mem_pll_tick));

    crs_strap_decoder u_crs_strap_decoder (.sys_clk(sys_clk), .reset_n(reset_n),
        .platform_ratio_straps(pins[11:9]), .core0_ratio_strap_hi(pins[8]),
        .core0_ratio_strap_mid(pins[7]), .core0_ratio_strap_lo(pins[6]),
        .core1_ratio_strap_hi(pins[5]), .core1_ratio_strap_mid(pins[4]),
        .core1_ratio_strap_lo(pins[3]), .mem_ratio_strap_hi(pins[2]),
        .mem_ratio_strap_mid(pins[1]), .mem_ratio_strap_lo(pins[0]),
        .platform_tick(platform_tick), .mem_pll_tick(mem_pll_tick), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .clk_cfg(clk_cfg), .cfg_valid(cfg_valid), .platform_run(platform_run),
        .bus_tick(bus_tick), .core0_clk_en(core0_clk_en), .core1_clk_en(core1_clk_en),
        .mem_pll_enable(mem_pll_enable), .mem_data_tick(mem_data_tick),
        .memory_clock_outputs_ctl0(mck0), .memory_clock_outputs_ctl0_inv(mck0_n),
        .memory_clock_outputs_ctl1(mck1), .memory_clock_outputs_ctl1_inv(mck1_n));

    // ************************************************************
    // Compare, bus and closing tasks
    // ************************************************************
    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            error_cnt++;
        end
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
            error_cnt++;
        end
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        d = reg_rdata;
    endtask

    task automatic tally_and_finish;
        if (error_cnt == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ************************************************************
    // Expectations and clock monitor
    // ************************************************************
    function automatic crs_pkg::crs_cfg_t exp_cfg(input crs_pkg::crs_straps_t s);
        crs_pkg::crs_cfg_t c;
        c.plat_mult = PM[s.plat];
        c.plat_err = (s.plat > 3'h5);
        c.core0_err = (s.core0 < 3'h3);
        c.core1_err = (s.core1 < 3'h3);
        c.core0_halves = c.core0_err ? 4'h0 : {1'b0, s.core0};
        c.core1_halves = c.core1_err ? 4'h0 : {1'b0, s.core1};
        c.mem_async = (s.mem != 3'h7);
        c.mem_mult = MM[s.mem];
        return c;
    endfunction

    always @(negedge sys_clk)
    begin
        if (mon_on)
        begin
            chk_bit("mem_data_tick", exp_run & exp_en & (exp_async ? mem_pll_tick : platform_tick),
                mem_data_tick);
            chk_bit("bus_tick", platform_tick & exp_run, bus_tick);
            chk_word("mck_ctl1", {20'h0, mck0, mck0}, {20'h0, mck1, mck1_n ^ 6'h3F});
            chk_word("mck_inv", {26'h0, ~mck0}, {26'h0, mck0_n});
            if (mon_prev)
                chk_word("mck_toggle", {26'h0, prev_mck ^ {6{prev_tick}}}, {26'h0, mck0});
        end
        mon_prev = mon_on;
        prev_mck = mck0;
        prev_tick = mem_data_tick;
    end

    // ************************************************************
    // Scenario: one strap set across a fresh reset
    // ************************************************************
    task automatic run_cfg(input crs_pkg::crs_straps_t s, input logic en);
        crs_pkg::crs_cfg_t e;
        logic [31:0] d;
        e = exp_cfg(s);
        @(posedge sys_clk);
        mon_on <= 1'b0;
        reset_n <= 1'b0;
        straps <= s;
        exp_run = !e.plat_err;
        exp_async = e.mem_async;
        exp_en = 1'b1;
        @(negedge sys_clk);
        chk_bit("cfg_valid_rst", 1'b0, cfg_valid);
        chk_word("mck_rst", 32'h0000003F, {20'h0, mck0, mck0_n});
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk_word("clk_cfg", {12'h000, e}, {12'h000, clk_cfg});
        chk_bit("cfg_valid", 1'b1, cfg_valid);
        chk_word("enables", {28'h0, exp_run, exp_run & !e.core0_err, exp_run & !e.core1_err,
            exp_run & e.mem_async}, {28'h0, platform_run, core0_clk_en, core1_clk_en,
            mem_pll_enable});
        reg_read(crs_pkg::CRS_ADDR_CTRL, d);
        chk_word("ctrl_rst", 32'h00000001, d);
        reg_write(crs_pkg::CRS_ADDR_STATUS, 32'hFFFFFFFF);
        reg_write(crs_pkg::CRS_ADDR_RATIO, 32'h00000000);
        reg_read(crs_pkg::CRS_ADDR_STATUS, d);
        chk_word("status", {26'h0, exp_run, e.mem_async, e.core1_err, e.core0_err, e.plat_err,
            1'b1}, d);
        reg_read(crs_pkg::CRS_ADDR_RATIO, d);
        chk_word("ratio", {4'h0, s, e.mem_mult, e.core1_halves, e.core0_halves, e.plat_mult},
            d);
        reg_read(4'hC, d);
        chk_word("unmapped", 32'h00000000, d);
        reg_write(crs_pkg::CRS_ADDR_CTRL, {31'h0, en});
        exp_en = en;
        mon_on <= 1'b1;
        repeat (24) @(posedge sys_clk);
        mon_on <= 1'b0;
        @(negedge sys_clk);
        chk_word("clk_cfg_held", {12'h000, e}, {12'h000, clk_cfg});
    endtask

    initial
    begin
        int i;
        crs_pkg::crs_straps_t s;
        void'($urandom(65));
        for (i = 0; i < 8; i++)
        begin
            s = {i[2:0], i[2:0], 3'(7 - i), i[2:0]};
            run_cfg(s, i[0]);
        end
        for (i = 0; i < 12; i++)
        begin
            s = 12'($urandom());
            run_cfg(s, 1'($urandom()));
        end
        tally_and_finish;
    end

    // Cuts a hung run short
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        tally_and_finish;
    end
endmodule
